// File: logic/cmc_pkg.sv
// package: register map, field positions, reset values and timing counts
package cmc_pkg;
  localparam logic [7:0] ctl_offset = 8'h00;
  localparam logic [7:0] stat_offset = 8'h04;
  localparam logic [31:0] ctl_reset = 32'h00010002;
  localparam logic [31:0] stat_reset = 32'h00000C02;
  localparam logic [31:0] ctl_rw_mask = 32'h000100FF;
  localparam int freeze_pos = 16;
  localparam int soft_reset_bit_pos = 15;
  localparam int ttc_pos = 7;
  localparam int auto_busoff_recovery_pos = 6;
  localparam int awu_pos = 5;
  localparam int ard_pos = 4;
  localparam int rx_overwrite_disable_pos = 3;
  localparam int tfo_pos = 2;
  localparam int sleep_pos = 1;
  localparam int init_pos = 0;
  localparam int stat_init_pos = 0;
  localparam int stat_sleep_pos = 1;
  localparam int stat_slpif_pos = 4;
  localparam int stat_wuif_pos = 3;
  localparam int stat_tx_pos = 8;
  localparam int stat_rx_pos = 9;
  localparam int stat_lastrx_pos = 10;
  localparam int stat_rxl_pos = 11;
  localparam logic [3:0] recessive_run = 4'hB;
  localparam logic [7:0] busoff_sequences = 8'h80;
  typedef enum logic [1:0] {
    cmc_sleep,
    cmc_init,
    cmc_normal
  } cmc_mode_type;
  typedef struct packed {
    logic freeze_active;
    logic time_triggered_enable;
    logic retransmit_disable;
    logic rx_overwrite_disable;
    logic tx_order_select;
    logic soft_reset_pulse;
  } cmc_opts_type;
endpackage

// File: logic/cmc_recessive_counter.sv
// counter of runs of consecutive recessive bits on the receive line
`timescale 1ns/10ps
`default_nettype none
module cmc_recessive_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic bit_tick,
  input wire logic rx_bit,
  output logic run_done
);
  logic [3:0] run_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 4'h0;
      run_done <= 1'b0;
    end else begin
      run_done <= 1'b0;
      if (clear || (bit_tick && !rx_bit)) begin
        run_q <= 4'h0;
      end else if (bit_tick) begin
        if (run_q == cmc_pkg::recessive_run - 4'h1) begin
          run_q <= 4'h0;
          run_done <= 1'b1;
        end else begin
          run_q <= run_q + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/cmc_top.sv
// can mode and option control with apb register slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module cmc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debug_hold_input,
  input wire logic bit_tick,
  input wire logic rx_bit,
  input wire logic frame_busy,
  input wire logic tx_busy,
  input wire logic rx_busy,
  input wire logic busoff_enter,
  input wire logic rx_fifo_full,
  input wire logic rx_frame_valid,
  output logic rx_store,
  output logic rx_overwrite,
  output logic busoff_state,
  output logic init_state_flag,
  output logic sleep_state_flag,
  output cmc_pkg::cmc_opts_type opts
);
  logic [31:0] ctl_q;
  logic [31:0] slp_flags_q;
  cmc_pkg::cmc_mode_type mode_q;
  logic leaving_init_q;
  logic wr_en;
  logic soft_reset_bit_hit;
  logic run_done;
  logic run_clear;
  logic activity;
  logic last_rx_q;
  logic [7:0] seq_q;
  logic manual_armed_q;
  logic frozen;

  assign wr_en = psel && penable && pwrite;
  assign soft_reset_bit_hit = wr_en && (paddr == cmc_pkg::ctl_offset) && pwdata[cmc_pkg::soft_reset_bit_pos];
  assign frozen = debug_hold_input && ctl_q[cmc_pkg::freeze_pos];
  // a falling edge on rx while asleep counts as bus activity
  assign activity = bit_tick && last_rx_q && !rx_bit;
  // idle runs restart on entering normal mode or bus-off, so bits seen earlier never count;
  // limitation: bus-off recovery only progresses while in normal mode
  assign run_clear = frozen || busoff_enter || (mode_q != cmc_pkg::cmc_normal);

  cmc_recessive_counter u_run (
    .pclk(pclk),
    .presetn(presetn),
    .clear(run_clear),
    .bit_tick(bit_tick),
    .rx_bit(rx_bit),
    .run_done(run_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_rx_q <= 1'b1;
    end else if (bit_tick) begin
      last_rx_q <= rx_bit;
    end
  end

  // control register; hardware clear of sleep request beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= cmc_pkg::ctl_reset;
    end else if (soft_reset_bit_hit) begin
      ctl_q <= cmc_pkg::ctl_reset;
    end else begin
      if (wr_en && paddr == cmc_pkg::ctl_offset) begin
        ctl_q <= pwdata & cmc_pkg::ctl_rw_mask;
      end
      if (mode_q == cmc_pkg::cmc_sleep && ctl_q[cmc_pkg::awu_pos] && activity) begin
        ctl_q[cmc_pkg::sleep_pos] <= 1'b0;
      end
    end
  end

  // working mode machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= cmc_pkg::cmc_sleep;
      leaving_init_q <= 1'b0;
    end else if (soft_reset_bit_hit) begin
      mode_q <= cmc_pkg::cmc_sleep;
      leaving_init_q <= 1'b0;
    end else begin
      unique case (mode_q)
        cmc_pkg::cmc_sleep: begin
          // without auto wakeup only an init request or the sleep request bit going low wakes us
          if (ctl_q[cmc_pkg::init_pos]) begin
            mode_q <= cmc_pkg::cmc_init;
          end else if (!ctl_q[cmc_pkg::sleep_pos]) begin
            mode_q <= cmc_pkg::cmc_normal;
            leaving_init_q <= 1'b1;
          end
        end
        cmc_pkg::cmc_init: begin
          if (!ctl_q[cmc_pkg::init_pos]) begin
            if (ctl_q[cmc_pkg::sleep_pos]) begin
              mode_q <= cmc_pkg::cmc_sleep;
            end else begin
              mode_q <= cmc_pkg::cmc_normal;
              leaving_init_q <= 1'b1;
            end
          end
        end
        cmc_pkg::cmc_normal: begin
          if (run_done) begin
            leaving_init_q <= 1'b0;
          end
          if (!frame_busy && ctl_q[cmc_pkg::init_pos]) begin
            mode_q <= cmc_pkg::cmc_init;
            leaving_init_q <= 1'b0;
          end else if (!frame_busy && ctl_q[cmc_pkg::sleep_pos]) begin
            mode_q <= cmc_pkg::cmc_sleep;
            leaving_init_q <= 1'b0;
          end
        end
        default: mode_q <= cmc_pkg::cmc_sleep;
      endcase
    end
  end

  // flags: init/sleep state held until the eleven-bit idle run after leaving into normal mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_state_flag <= 1'b0;
      sleep_state_flag <= 1'b1;
    end else if (soft_reset_bit_hit) begin
      init_state_flag <= 1'b0;
      sleep_state_flag <= 1'b1;
    end else begin
      init_state_flag <= (mode_q == cmc_pkg::cmc_init) ||
                         (init_state_flag && leaving_init_q && !run_done);
      sleep_state_flag <= (mode_q == cmc_pkg::cmc_sleep) ||
                          (sleep_state_flag && leaving_init_q && !run_done);
    end
  end

  // sleep entry and wakeup flags, write one to clear; a set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp_flags_q <= 32'h00000000;
    end else begin
      if (wr_en && paddr == cmc_pkg::stat_offset) begin
        slp_flags_q[cmc_pkg::stat_slpif_pos] <= slp_flags_q[cmc_pkg::stat_slpif_pos] &
                                                 !pwdata[cmc_pkg::stat_slpif_pos];
        slp_flags_q[cmc_pkg::stat_wuif_pos] <= slp_flags_q[cmc_pkg::stat_wuif_pos] &
                                                !pwdata[cmc_pkg::stat_wuif_pos];
      end
      if (mode_q != cmc_pkg::cmc_sleep) begin
        slp_flags_q[cmc_pkg::stat_slpif_pos] <= 1'b0;
      end else if (!sleep_state_flag) begin
        slp_flags_q[cmc_pkg::stat_slpif_pos] <= 1'b1;
      end
      if (mode_q == cmc_pkg::cmc_sleep && activity) begin
        slp_flags_q[cmc_pkg::stat_wuif_pos] <= 1'b1;
      end
    end
  end

  // bus-off: 128 eleven-bit runs; manual mode first needs init entered and left
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busoff_state <= 1'b0;
      seq_q <= 8'h00;
      manual_armed_q <= 1'b0;
    end else if (soft_reset_bit_hit) begin
      busoff_state <= 1'b0;
      seq_q <= 8'h00;
      manual_armed_q <= 1'b0;
    end else if (busoff_enter) begin
      busoff_state <= 1'b1;
      seq_q <= 8'h00;
      manual_armed_q <= 1'b0;
    end else if (busoff_state) begin
      if (mode_q == cmc_pkg::cmc_init) begin
        manual_armed_q <= 1'b1;
      end
      if ((ctl_q[cmc_pkg::auto_busoff_recovery_pos] || (manual_armed_q && mode_q == cmc_pkg::cmc_normal)) &&
          run_done) begin
        if (seq_q == cmc_pkg::busoff_sequences - 8'h01) begin
          busoff_state <= 1'b0;
          seq_q <= 8'h00;
        end else begin
          seq_q <= seq_q + 8'h01;
        end
      end
    end
  end

  // receive fifo full policy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_store <= 1'b0;
      rx_overwrite <= 1'b0;
    end else begin
      rx_store <= rx_frame_valid && !frozen &&
                  (!rx_fifo_full || !ctl_q[cmc_pkg::rx_overwrite_disable_pos]);
      rx_overwrite <= rx_frame_valid && !frozen && rx_fifo_full &&
                      !ctl_q[cmc_pkg::rx_overwrite_disable_pos];
    end
  end

  // option outputs to the protocol engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opts <= '0;
    end else begin
      opts.freeze_active <= frozen;
      opts.time_triggered_enable <= ctl_q[cmc_pkg::ttc_pos];
      opts.retransmit_disable <= ctl_q[cmc_pkg::ard_pos];
      opts.rx_overwrite_disable <= ctl_q[cmc_pkg::rx_overwrite_disable_pos];
      opts.tx_order_select <= ctl_q[cmc_pkg::tfo_pos];
      opts.soft_reset_pulse <= soft_reset_bit_hit;
    end
  end

  // apb slave: zero wait states, unmapped reads zero with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable &&
                 (paddr != cmc_pkg::ctl_offset) && (paddr != cmc_pkg::stat_offset);
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        if (paddr == cmc_pkg::ctl_offset) begin
          prdata <= ctl_q;
        end else if (paddr == cmc_pkg::stat_offset) begin
          prdata <= slp_flags_q;
          prdata[cmc_pkg::stat_init_pos] <= init_state_flag;
          prdata[cmc_pkg::stat_sleep_pos] <= sleep_state_flag;
          prdata[cmc_pkg::stat_tx_pos] <= tx_busy;
          prdata[cmc_pkg::stat_rx_pos] <= rx_busy;
          prdata[cmc_pkg::stat_lastrx_pos] <= last_rx_q;
          prdata[cmc_pkg::stat_rxl_pos] <= rx_bit;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/cmc_top_sva.sv
// checker for the can mode control block
`timescale 1ns/10ps
`default_nettype none
module cmc_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic debug_hold_input,
  input wire logic bit_tick,
  input wire logic rx_bit,
  input wire logic frame_busy,
  input wire logic rx_fifo_full,
  input wire logic rx_frame_valid,
  input wire logic rx_store,
  input wire logic rx_overwrite,
  input wire logic init_state_flag,
  input wire logic sleep_state_flag,
  input wire cmc_pkg::cmc_opts_type opts
);
  logic [3:0] run_q;
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // saturating run of recessive samples, a floor for an exit from init into normal mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_q <= 4'h0;
    else if (bit_tick) run_q <= !rx_bit ? 4'h0 : run_q + {3'h0, run_q != 4'hF};
  end
  a_slverr_unmap: assert property (psel && !penable && paddr != 8'h00 && paddr != 8'h04
    |=> pslverr && pready) else $error("slverr");
  a_ctl_reserved: assert property (pready && !pwrite && paddr == 8'h00
    |-> prdata[31:17] == 15'h0 && prdata[15:8] == 8'h0) else $error("ctl reserved");
  // opts trails the register by a cycle, so the policy in force is read one cycle later
  a_ovw_enabled: assert property (rx_frame_valid && rx_fifo_full
    |=> rx_overwrite == (!opts.rx_overwrite_disable && !opts.freeze_active)) else $error("ovw");
  a_drop_full: assert property (rx_frame_valid && rx_fifo_full
    |=> (opts.rx_overwrite_disable |-> !rx_store && !rx_overwrite)) else $error("drop");
  a_soft_reset_bit_pulse: assert property (psel && penable && pready && pwrite && paddr == 8'h00
    && pwdata[15] |-> ##[1:2] opts.soft_reset_pulse ##1 !opts.soft_reset_pulse) else $error("soft_reset_bit");
  a_freeze_hold: assert property (opts.freeze_active |-> $past(debug_hold_input))
    else $error("freeze");
  a_sleep_frame: assert property ($rose(sleep_state_flag) && !opts.soft_reset_pulse
    && !$past(psel && pwrite && pwdata[15]) && !$past(init_state_flag)
    |-> !$past(frame_busy)) else $error("sleep");
  a_init_run: assert property ($fell(init_state_flag) && !sleep_state_flag
    |-> run_q >= 4'hB) else $error("init run");
endmodule
bind cmc_top cmc_top_sva u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .debug_hold_input(debug_hold_input), .bit_tick(bit_tick), .rx_bit(rx_bit),
  .frame_busy(frame_busy), .rx_fifo_full(rx_fifo_full), .rx_frame_valid(rx_frame_valid),
  .rx_store(rx_store), .rx_overwrite(rx_overwrite), .init_state_flag(init_state_flag),
  .sleep_state_flag(sleep_state_flag), .opts(opts));
`default_nettype wire

// File: tb/cmc_bus_node.sv
// far-side node model: bit sample pulses and a short frame on request
`timescale 1ns/10ps
`default_nettype none
module cmc_bus_node (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  output logic bit_tick,
  output logic rx_bit,
  output logic frame_busy
);
  logic [1:0] div_q;
  logic [4:0] cnt_q;
  // four clocks a bit keeps the recovery wait short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {div_q, cnt_q, bit_tick, frame_busy, rx_bit} <= 10'h1;
    end else begin
      div_q <= div_q + 2'h1;
      bit_tick <= div_q == 2'h3;
      if (div_q == 2'h3) begin
        frame_busy <= cnt_q != 5'h0 || send;
        cnt_q <= cnt_q != 5'h0 ? cnt_q - 5'h1 : (send ? 5'h13 : 5'h0);
        rx_bit <= cnt_q != 5'h0 ? cnt_q[0] ^ cnt_q[2] : !send;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the can mode control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, debug_hold_input, tx_busy, rx_busy, busoff_enter;
  logic rx_fifo_full, rx_frame_valid, send, pready, pslverr, bit_tick, rx_bit, frame_busy;
  logic rx_store, rx_overwrite, busoff_state, init_state_flag, sleep_state_flag, err_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q, wd;
  cmc_pkg::cmc_opts_type opts;
  int err_total = 0, check_count = 0, seed = 32'h64C32721, k;
  wire logic [3:0] flags = {frame_busy, busoff_state, sleep_state_flag, init_state_flag};
  always #25 pclk = ~pclk;
  cmc_bus_node i_node (.pclk, .presetn, .send, .bit_tick, .rx_bit, .frame_busy);
  cmc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .debug_hold_input, .bit_tick, .rx_bit, .frame_busy, .tx_busy, .rx_busy,
    .busoff_enter, .rx_fifo_full, .rx_frame_valid, .rx_store, .rx_overwrite, .busoff_state,
    .init_state_flag, .sleep_state_flag, .opts);
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic hang;
    err_total++;
    $display("MISMATCH wait expected event seen timeout");
    report_and_stop;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) hang;
    {rd_q, err_q} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
    apb(1'h0, a, 32'h0);
    chk(s, x, rd_q);
  endtask
  task automatic wt(input int f, input logic v, input int lim);
    int n;
    n = 0;
    while (flags[f] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (flags[f] !== v) hang;
  endtask
  task automatic frm;
    send <= 1'h1;
    repeat (8) @(posedge pclk);
    send <= 1'h0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, debug_hold_input, tx_busy, rx_busy} = '0;
    {busoff_enter, rx_fifo_full, rx_frame_valid, send, paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd(8'h00, 32'h00010002, "ctl");
    rd(8'h04, 32'h00000C02, "stat");
    for (k = 0; k < 6; k++) begin
      // first pass is a hand-picked corner: freeze bit set under debug hold
      wd = ($random(seed) & 32'hFFFF7FFF) | {15'h0, k == 0, 16'h0};
      {debug_hold_input, tx_busy, rx_busy} <= 3'($random(seed)) | {k == 0, 2'h0};
      apb(1'h1, 8'h00, wd);
      rd(8'h00, wd & 32'h000100FF, "ctl");
      chk("opts", {wd[16] & debug_hold_input, wd[7], wd[4], wd[3], wd[2], 1'h0}, opts);
      apb(1'h0, 8'h04, 32'h0);
      chk("stat", {20'h0, rx_busy, tx_busy}, {rd_q[31:12], rd_q[9:8]});
    end
    $display("test registers done");
    debug_hold_input <= 1'h0;
    apb(1'h1, 8'h00, 32'h00008000);
    rd(8'h00, 32'h00010002, "soft_reset_bit");
    chk("sleep", 1'h1, sleep_state_flag);
    apb(1'h1, 8'h00, 32'h1);
    wt(0, 1'h1, 50);
    apb(1'h1, 8'h00, 32'h0);
    chk("init", 1'h1, init_state_flag);
    wt(0, 1'h0, 200);
    frm;
    apb(1'h1, 8'h00, 32'h2);
    // the frame is still on the bus, so the request must wait for it
    repeat (4) @(posedge pclk);
    #1 chk("sleep", 1'h0, sleep_state_flag);
    wt(1, 1'h1, 200);
    frm;
    wt(3, 1'h0, 200);
    // longer than an eleven-bit recessive run at four clocks a bit
    repeat (60) @(posedge pclk);
    chk("sleep", 1'h1, sleep_state_flag);
    rd(8'h00, 32'h2, "ctl");
    apb(1'h0, 8'h04, 32'h0);
    chk("wake flags", 32'h3, rd_q[4:3]);
    apb(1'h1, 8'h04, 32'h18);
    apb(1'h0, 8'h04, 32'h0);
    chk("wake flags", 32'h0, rd_q[4:3]);
    apb(1'h1, 8'h00, 32'h22);
    frm;
    wt(1, 1'h0, 300);
    rd(8'h00, 32'h20, "ctl");
    $display("test modes done");
    rx_fifo_full <= 1'h1;
    for (k = 0; k < 2; k++) begin
      apb(1'h1, 8'h00, k * 8);
      rx_frame_valid <= 1'h1;
      @(posedge pclk);
      rx_frame_valid <= 1'h0;
      #1 chk("ovw", k == 0, rx_overwrite);
      chk("store", k == 0, rx_store);
    end
    rx_fifo_full <= 1'h0;
    apb(1'h1, 8'h00, 32'h40);
    busoff_enter <= 1'h1;
    @(posedge pclk);
    busoff_enter <= 1'h0;
    wt(2, 1'h1, 5);
    // 125 runs of eleven bits: still short of the 128 needed
    repeat (5500) @(posedge pclk);
    chk("busoff", 1'h1, busoff_state);
    wt(2, 1'h0, 400);
    apb(1'h1, 8'h00, 32'h0);
    busoff_enter <= 1'h1;
    @(posedge pclk);
    busoff_enter <= 1'h0;
    // manual recovery: idle runs alone must not end bus-off
    repeat (5700) @(posedge pclk);
    #1 chk("busoff", 1'h1, busoff_state);
    apb(1'h1, 8'h00, 32'h1);
    wt(0, 1'h1, 50);
    apb(1'h1, 8'h00, 32'h0);
    wt(2, 1'h0, 5800);
    rd(8'h08, 32'h0, "unmapped");
    chk("slverr", 1'h1, err_q);
    $display("test fifo and busoff done");
    report_and_stop;
  end
endmodule
`default_nettype wire
